// [dv/power_mgmt_config_regs_tb.sv]
// self-checking bench of the power-management register bank
`timescale 1ns/1ps
`default_nettype none
`include "power_mgmt_map.svh"
module power_mgmt_config_regs_tb;
    import power_mgmt_pkg::*;
    logic clk = 0, resetn = 0, sfr_wr = 0, main_low = 0, dcin_low = 0, main_ready = 1;
    logic pll_lock_lost = 0, pll_fault_ack = 0, rx_wake_event = 0;
    logic rail_source, sleep_reference_enable, rx_is_serial, rx_wake_enable, power_irq;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, power_irq_flags = 8'h00, sfr_rdata;
    switchover_mode_t      switchover_mode;
    receive_pin_function_t receive_pin_function;
    int errors = 0, compares = 0;
    power_mgmt_config_regs power_mgmt_config_regs_inst (.clk(clk), .resetn(resetn),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .main_low(main_low), .dcin_low(dcin_low), .main_ready(main_ready),
        .pll_lock_lost(pll_lock_lost), .pll_fault_ack(pll_fault_ack),
        .rx_wake_event(rx_wake_event), .power_irq_flags(power_irq_flags),
        .switchover_mode(switchover_mode), .receive_pin_function(receive_pin_function),
        .rail_source(rail_source), .sleep_reference_enable(sleep_reference_enable),
        .rx_is_serial(rx_is_serial), .rx_wake_enable(rx_wake_enable), .power_irq(power_irq));
    always #10 clk = ~clk;
    task automatic give_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        wait_edges(1);
        chk(sfr_rdata, exp);
    endtask : rd_chk
    task automatic test_reset;
        rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h60);
        rd_chk(`PM_OFF_IRQ_ENABLE, 8'h00);
        rd_chk(`PM_OFF_BATTERY, 8'h00);
        for (int i = 0; i < 3; i++) rd_chk(`PM_OFF_SCRATCH_ONE + i, 8'h00);
        chk({6'h0, switchover_mode}, 8'h00);
        @(posedge clk) main_ready <= 1'b0;
        rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h40);
        @(posedge clk) main_ready <= 1'b1;
    endtask : test_reset
    task automatic test_scratch;
        logic [7:0] v[3] = '{8'h5a, 8'ha5, 8'hff};
        for (int i = 0; i < 3; i++) wr(`PM_OFF_SCRATCH_ONE + i, v[i]);
        wr(8'h10, 8'h77);
        for (int i = 0; i < 3; i++) rd_chk(`PM_OFF_SCRATCH_ONE + i, v[i]);
        rd_chk(8'h10, 8'h00);
    endtask : test_scratch
    task automatic test_switchover;
        logic exp;
        for (int m = 0; m < 4; m++) begin
            wr(`PM_OFF_BATTERY, 8'(m));
            rd_chk(`PM_OFF_BATTERY, 8'(m));
            for (int c = 0; c < 4; c++) begin
                @(posedge clk);
                main_low <= c[0];
                dcin_low <= c[1];
                wait_edges(1);
                exp = !((m == 0 && c[0]) || (m == 1 && c != 0));
                chk({7'h0, rail_source}, {7'h0, exp});
                rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, {1'b0, exp, 6'h20});
            end
        end
        wr(`PM_OFF_BATTERY, 8'h00);
        @(posedge clk) {main_low, dcin_low} <= 2'b00;
    endtask : test_switchover
    task automatic test_peripheral_config_status;
        for (int c = 0; c < 4; c++) begin
            wr(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'(c));
            wait_edges(0);
            chk({6'h0, receive_pin_function}, 8'(c));
            chk({6'h0, rx_wake_enable, rx_is_serial}, {6'h0, c == 3, c[0]});
        end
        for (int c = 1; c < 4; c += 2) begin
            wr(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'(c));
            @(posedge clk) rx_wake_event <= 1'b1;
            @(posedge clk) rx_wake_event <= 1'b0;
            rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, {c == 3, 7'h60 | 7'(c)});
        end
        wr(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h03);
        rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h63);
        @(posedge clk) pll_lock_lost <= 1'b1;
        @(posedge clk) pll_lock_lost <= 1'b0;
        repeat (2) rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h73);
        @(posedge clk) pll_fault_ack <= 1'b1;
        @(posedge clk) pll_fault_ack <= 1'b0;
        rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h63);
        wr(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h08);
        wait_edges(0);
        chk({7'h0, sleep_reference_enable}, 8'h01);
        rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h68);
    endtask : test_peripheral_config_status
    task automatic test_irq;
        int b[6] = '{7, 5, 3, 2, 1, 0};
        for (int i = 0; i < 6; i++) begin
            wr(`PM_OFF_IRQ_ENABLE, 8'h01 << b[i]);
            rd_chk(`PM_OFF_IRQ_ENABLE, 8'h01 << b[i]);
            @(posedge clk) power_irq_flags <= ~(8'h01 << b[i]);
            wait_edges(0);
            chk({7'h0, power_irq}, 8'h00);
            @(posedge clk) power_irq_flags <= 8'h01 << b[i];
            wait_edges(0);
            chk({7'h0, power_irq}, 8'h01);
            rd_chk(`PM_OFF_IRQ_FLAGS, 8'h01 << b[i]);
        end
        wr(`PM_OFF_IRQ_ENABLE, 8'hef);
        rd_chk(`PM_OFF_IRQ_ENABLE, 8'hef);
        wr(`PM_OFF_IRQ_FLAGS, 8'h00);
        rd_chk(`PM_OFF_IRQ_FLAGS, 8'h01);
    endtask : test_irq
    task automatic test_set_wins;
        wr(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h03);
        @(posedge clk);
        sfr_addr <= `PM_OFF_PERIPHERAL_CONFIG_STATUS;
        sfr_wdata <= 8'h03;
        sfr_wr <= 1'b1;
        rx_wake_event <= 1'b1;
        pll_lock_lost <= 1'b1;
        pll_fault_ack <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        rx_wake_event <= 1'b0;
        pll_lock_lost <= 1'b0;
        pll_fault_ack <= 1'b0;
        rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'hf3);
        wr(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h03);
        rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h73);
        @(posedge clk) pll_fault_ack <= 1'b1;
        @(posedge clk) pll_fault_ack <= 1'b0;
        rd_chk(`PM_OFF_PERIPHERAL_CONFIG_STATUS, 8'h63);
    endtask : test_set_wins
    task automatic test_midreset;
        wr(`PM_OFF_SCRATCH_TWO, 8'h3c);
        wr(`PM_OFF_BATTERY, 8'h02);
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(`PM_OFF_SCRATCH_TWO, 8'h00);
        rd_chk(`PM_OFF_BATTERY, 8'h00);
        rd_chk(`PM_OFF_IRQ_ENABLE, 8'h00);
        wait_edges(0);
        chk({7'h0, power_irq}, 8'h00);
        chk({7'h0, rail_source}, 8'h01);
    endtask : test_midreset
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        test_reset();
        test_scratch();
        test_switchover();
        test_peripheral_config_status();
        test_set_wins();
        test_irq();
        test_midreset();
        give_verdict();
    end
    initial begin
        #(20 * 5000);
        errors++;
        give_verdict();
    end
endmodule : power_mgmt_config_regs_tb
`default_nettype wire

// [verilog/power_mgmt_config_regs.sv]
// power-management special function registers
// Contract
// - mode 00 main-low switchover, 01 main or dcin low, 1X none; reset 00.
// - receive-wake flag bit 7 set on rx-edge wake from deep sleep.
// - bit 6 reads 1 on main supply, 0 on battery; reset 1.
// - bit 5 reads 1 when main supply ready; follows main_ready live, no reset value.
// - pll fault bit 4 set on lock loss, cleared by fault acknowledge.
// - bit 3 keeps voltage reference enabled in deep sleep.
// - receive-pin field 00 gpio, 01 rx no wake, 11 rx with wake.
// - enable bit 7 gates supply-restored flag onto interrupt; reset 0.
// - enable bit 5 gates sag flag onto interrupt; reset 0.
// - enable bit 3 gates dc-input converter flag onto interrupt.
// - enable bit 2 gates battery monitor flag onto interrupt.
// - enable bit 1 gates switchover flag onto interrupt.
// - enable bit 0 gates dc-input low flag onto interrupt.
// - three scratch registers read/write, reset zero, kept in sleep modes.
// - flag register bit positions match the enable bits.
// - switchover disabled keeps the rail on main supply.
// - switch to battery on main low, or dcin low when chosen.
`timescale 1ns/1ps
`default_nettype none
`include "power_mgmt_map.svh"
module power_mgmt_config_regs (
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    input  wire logic [7:0]                            sfr_addr,
    input  wire logic                                  sfr_wr,
    input  wire logic [7:0]                            sfr_wdata,
    output logic      [7:0]                            sfr_rdata,
    input  wire logic                                  main_low,
    input  wire logic                                  dcin_low,
    input  wire logic                                  main_ready,
    input  wire logic                                  pll_lock_lost,
    input  wire logic                                  pll_fault_ack,
    input  wire logic                                  rx_wake_event,
    input  wire logic [7:0]                            power_irq_flags,
    output var power_mgmt_pkg::switchover_mode_t       switchover_mode,
    output var power_mgmt_pkg::receive_pin_function_t  receive_pin_function,
    output logic                                       rail_source,
    output logic                                       sleep_reference_enable,
    output logic                                       rx_is_serial,
    output logic                                       rx_wake_enable,
    output logic                                       power_irq
);
    import power_mgmt_pkg::*;

    logic [7:0]              irq_en_q, irq_en_d;
    switchover_mode_t        sw_mode_q, sw_mode_d;
    receive_pin_function_t   rx_fn_q, rx_fn_d;
    logic                    rx_flag_q, rx_flag_d;
    logic                    pll_fault_q, pll_fault_d;
    logic                    sleep_ref_q, sleep_ref_d;
    logic                    rail_main_q, rail_main_d;
    logic [7:0]              scr1_q, scr1_d;
    logic [7:0]              scr2_q, scr2_d;
    logic [7:0]              scr3_q, scr3_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic wr_peripheral_config_status;
    assign wr_peripheral_config_status = sfr_wr && hit(sfr_addr, `PM_OFF_PERIPHERAL_CONFIG_STATUS);

    // register writes and hardware-set status
    always_comb begin
        irq_en_d    = irq_en_q;
        sw_mode_d   = sw_mode_q;
        rx_fn_d     = rx_fn_q;
        sleep_ref_d = sleep_ref_q;
        scr1_d      = scr1_q;
        scr2_d      = scr2_q;
        scr3_d      = scr3_q;
        if (sfr_wr) begin
            if (hit(sfr_addr, `PM_OFF_IRQ_ENABLE))
                irq_en_d = sfr_wdata & `PM_IRQ_EN_MASK;
            if (hit(sfr_addr, `PM_OFF_BATTERY))
                sw_mode_d = switchover_mode_t'(sfr_wdata[1:0]);
            if (hit(sfr_addr, `PM_OFF_SCRATCH_ONE))
                scr1_d = sfr_wdata;
            if (hit(sfr_addr, `PM_OFF_SCRATCH_TWO))
                scr2_d = sfr_wdata;
            if (hit(sfr_addr, `PM_OFF_SCRATCH_THREE))
                scr3_d = sfr_wdata;
        end
        if (wr_peripheral_config_status) begin
            sleep_ref_d = sfr_wdata[`PM_BIT_SLEEP_REF];
            rx_fn_d     = receive_pin_function_t'(sfr_wdata[1:0]);
        end
        // flag set wins over a write clearing it
        rx_flag_d = rx_flag_q;
        if (wr_peripheral_config_status && !sfr_wdata[`PM_BIT_RX_WAKE])
            rx_flag_d = 1'b0;
        if (rx_wake_event && rx_fn_q == RX_SERIAL_WAKE)
            rx_flag_d = 1'b1;
        pll_fault_d = pll_fault_q;
        if (pll_fault_ack)
            pll_fault_d = 1'b0;
        if (pll_lock_lost)
            pll_fault_d = 1'b1;
        // rail source follows switchover mode and supply comparators
        case (sw_mode_q)
            SW_MAIN_LOW:         rail_main_d = !main_low;
            SW_MAIN_OR_DCIN_LOW: rail_main_d = !(main_low || dcin_low);
            default:             rail_main_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_en_q    <= `PM_RST_IRQ_ENABLE;
            sw_mode_q   <= switchover_mode_t'(`PM_RST_SWITCHOVER);
            rx_fn_q     <= receive_pin_function_t'(`PM_RST_RX_FUNCTION);
            rx_flag_q   <= 1'b0;
            pll_fault_q <= 1'b0;
            sleep_ref_q <= 1'b0;
            rail_main_q <= 1'b1;
            scr1_q      <= `PM_RST_SCRATCH;
            scr2_q      <= `PM_RST_SCRATCH;
            scr3_q      <= `PM_RST_SCRATCH;
        end else begin
            irq_en_q    <= irq_en_d;
            sw_mode_q   <= sw_mode_d;
            rx_fn_q     <= rx_fn_d;
            rx_flag_q   <= rx_flag_d;
            pll_fault_q <= pll_fault_d;
            sleep_ref_q <= sleep_ref_d;
            rail_main_q <= rail_main_d;
            scr1_q      <= scr1_d;
            scr2_q      <= scr2_d;
            scr3_q      <= scr3_d;
        end
    end

    // read data registered; main-ready mirrored live
    logic [7:0] rdata_d, rdata_q, peripheral_config_status_val;
    always_comb begin
        peripheral_config_status_val = 8'h00;
        peripheral_config_status_val[`PM_BIT_RX_WAKE]     = rx_flag_q;
        peripheral_config_status_val[`PM_BIT_RAIL_SOURCE] = rail_main_q;
        peripheral_config_status_val[`PM_BIT_MAIN_READY]  = main_ready;
        peripheral_config_status_val[`PM_BIT_PLL_FAULT]   = pll_fault_q;
        peripheral_config_status_val[`PM_BIT_SLEEP_REF]   = sleep_ref_q;
        peripheral_config_status_val[1:0]                 = rx_fn_q;
        case (sfr_addr)
            `PM_OFF_IRQ_ENABLE:    rdata_d = irq_en_q;
            `PM_OFF_IRQ_FLAGS:     rdata_d = power_irq_flags & `PM_IRQ_EN_MASK;
            `PM_OFF_PERIPHERAL_CONFIG_STATUS:        rdata_d = peripheral_config_status_val;
            `PM_OFF_BATTERY:       rdata_d = {6'h00, sw_mode_q};
            `PM_OFF_SCRATCH_ONE:   rdata_d = scr1_q;
            `PM_OFF_SCRATCH_TWO:   rdata_d = scr2_q;
            `PM_OFF_SCRATCH_THREE: rdata_d = scr3_q;
            default:               rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end

    logic [7:0] irq_hits;
    // enabled flags raise the request
    assign irq_hits = power_irq_flags & irq_en_q;
    assign power_irq = |irq_hits;
    assign sfr_rdata = rdata_q;
    assign switchover_mode = sw_mode_q;
    assign receive_pin_function = rx_fn_q;
    assign rail_source = rail_main_q;
    assign sleep_reference_enable = sleep_ref_q;
    assign rx_is_serial = (rx_fn_q == RX_SERIAL) || (rx_fn_q == RX_SERIAL_WAKE);
    assign rx_wake_enable = (rx_fn_q == RX_SERIAL_WAKE);

    // checks
    chk_sw_off_main: assert property (@(posedge clk) disable iff (!resetn)
        sw_mode_q[1] |=> rail_main_q)
        else $error("rail left main with switchover off");
    chk_main_low_switch: assert property (@(posedge clk) disable iff (!resetn)
        (sw_mode_q == SW_MAIN_LOW && main_low) |=> !rail_main_q)
        else $error("no switch to battery on main low");
    chk_dcin_ignored: assert property (@(posedge clk) disable iff (!resetn)
        (sw_mode_q == SW_MAIN_LOW && !main_low && dcin_low) |=> rail_main_q)
        else $error("dcin low switched in main-only mode");
    chk_dcin_switch: assert property (@(posedge clk) disable iff (!resetn)
        (sw_mode_q == SW_MAIN_OR_DCIN_LOW && dcin_low) |=> !rail_main_q)
        else $error("no switch on dcin low");
    sequence pll_lost_s;
        pll_lock_lost;
    endsequence
    sequence pll_held_s;
        (pll_fault_q && !pll_fault_ack) [*2];
    endsequence
    chk_pll_fault_hold: assert property (@(posedge clk) disable iff (!resetn)
        pll_lost_s ##1 (!pll_fault_ack) |-> pll_held_s)
        else $error("pll fault not held until ack");
    chk_pll_fault_clear: assert property (@(posedge clk) disable iff (!resetn)
        (pll_fault_ack && !pll_lock_lost) |=> !pll_fault_q)
        else $error("pll fault not cleared by ack");
    chk_pll_set_wins: assert property (@(posedge clk) disable iff (!resetn)
        pll_lock_lost |=> pll_fault_q)
        else $error("pll fault lost to acknowledge");
    chk_rx_wake_set: assert property (@(posedge clk) disable iff (!resetn)
        (rx_wake_event && rx_fn_q == RX_SERIAL_WAKE) |=> rx_flag_q)
        else $error("receive wake flag not set");
    chk_irq_request: assert property (@(posedge clk) disable iff (!resetn)
        power_irq == |(power_irq_flags & irq_en_q))
        else $error("interrupt request mismatch");
    chk_scratch_write: assert property (@(posedge clk) disable iff (!resetn)
        (sfr_wr && sfr_addr == `PM_OFF_SCRATCH_ONE) |=> scr1_q == $past(sfr_wdata))
        else $error("scratch one write lost");
    chk_rx_code10_gpio: assert property (@(posedge clk) disable iff (!resetn)
        (rx_fn_q == RX_GPIO_ALT) |-> !rx_is_serial && !rx_wake_enable)
        else $error("code 10 not gpio");
endmodule : power_mgmt_config_regs
`default_nettype wire

// [verilog/power_mgmt_map.svh]
// register offsets, field positions and reset values of the power-management bank
`ifndef POWER_MGMT_MAP_SVH
`define POWER_MGMT_MAP_SVH
`define PM_OFF_IRQ_ENABLE     8'hec
`define PM_OFF_IRQ_FLAGS      8'hf8
`define PM_OFF_PERIPHERAL_CONFIG_STATUS         8'hf4
`define PM_OFF_BATTERY        8'hf5
`define PM_OFF_SCRATCH_ONE    8'hfb
`define PM_OFF_SCRATCH_TWO    8'hfc
`define PM_OFF_SCRATCH_THREE  8'hfd
`define PM_BIT_RESTORED       7
`define PM_BIT_SAG            5
`define PM_BIT_DCIN_CONV      3
`define PM_BIT_BATTERY_MON    2
`define PM_BIT_SWITCHOVER     1
`define PM_BIT_DCIN_LOW       0
`define PM_BIT_RX_WAKE        7
`define PM_BIT_RAIL_SOURCE    6
`define PM_BIT_MAIN_READY     5
`define PM_BIT_PLL_FAULT      4
`define PM_BIT_SLEEP_REF      3
`define PM_IRQ_EN_MASK        8'hef
`define PM_RST_IRQ_ENABLE     8'h00
`define PM_RST_SWITCHOVER     2'h0
`define PM_RST_RX_FUNCTION    2'h0
`define PM_RST_SCRATCH        8'h00
`endif

// [verilog/power_mgmt_pkg.sv]
// types of the power-management bank
package power_mgmt_pkg;
    typedef enum logic [1:0] {
        SW_MAIN_LOW,
        SW_MAIN_OR_DCIN_LOW,
        SW_OFF_A,
        SW_OFF_B
    } switchover_mode_t;
    typedef enum logic [1:0] {
        RX_GPIO,
        RX_SERIAL,
        RX_GPIO_ALT,
        RX_SERIAL_WAKE
    } receive_pin_function_t;
endpackage : power_mgmt_pkg
